/* File: pbcg_pkg.sv */
// Package for the peripheral bus clock gating block: register map, field layout and resets.
// Assumes a 32-bit APB register port with byte addresses and one aligned word per register.
package pbcg_pkg;

  // Register byte offsets.
  localparam logic [7:0] PBCG_OFS_MASK_A = 8'h18;
  localparam logic [7:0] PBCG_OFS_MASK_B = 8'h1C;
  localparam logic [7:0] PBCG_OFS_MASK_C = 8'h20;

  // Number of defined enable bits in each mask, counted from bit 0.
  localparam int PBCG_WIDTH_A = 7;
  localparam int PBCG_WIDTH_B = 5;
  localparam int PBCG_WIDTH_C = 20;

  // Reset values as printed; bits above each mask width are not stored.
  localparam logic [31:0] PBCG_RST_MASK_A = 32'h0000007F;
  localparam logic [31:0] PBCG_RST_MASK_B = 32'h0000007F;
  localparam logic [31:0] PBCG_RST_MASK_C = 32'h00010000;

  // Domain A enable positions.
  localparam int PBCG_A_EXT_IRQ_CTRL = 6;
  localparam int PBCG_A_REAL_TIME_COUNTER = 5;
  localparam int PBCG_A_WATCHDOG = 4;
  localparam int PBCG_A_GENERIC_CLOCK_UNIT = 3;
  localparam int PBCG_A_SYSTEM_CONTROLLER = 2;
  localparam int PBCG_A_POWER_MANAGER = 1;
  localparam int PBCG_A_ACCESS_PROTECT_ZERO = 0;

  // Domain B enable positions.
  localparam int PBCG_B_DMA_CONTROLLER = 4;
  localparam int PBCG_B_IO_PORT = 3;
  localparam int PBCG_B_FLASH_CONTROLLER = 2;
  localparam int PBCG_B_DEBUG_UNIT = 1;
  localparam int PBCG_B_ACCESS_PROTECT_ONE = 0;

  // Domain C enable positions; ranges give the lowest bit of a group.
  localparam int PBCG_C_TOUCH_CONTROLLER = 19;
  localparam int PBCG_C_DA_CONVERTER = 18;
  localparam int PBCG_C_ANALOG_COMPARATOR = 17;
  localparam int PBCG_C_AD_CONVERTER = 16;
  localparam int PBCG_C_BASIC_TIMER_LOW = 11;
  localparam int PBCG_C_CONTROL_TIMER_LOW = 8;
  localparam int PBCG_C_SERIAL_UNIT_LOW = 2;
  localparam int PBCG_C_EVENT_SYSTEM = 1;
  localparam int PBCG_C_ACCESS_PROTECT_TWO = 0;

endpackage

/* File: pbcg_clk_gate.sv */
// Glitch-free clock gate bank: one gated copy of the source clock per enable bit.
// Assumes the enables change only just after a rising edge of the same source clock.
`timescale 1ns/10ps
`default_nettype none
module pbcg_clk_gate #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] gated_clk
);

  logic [WIDTH-1:0] en_low_r;
  logic [WIDTH-1:0] en_low_nxt;

  // The enable is passed straight through to the low-phase register.
  always_comb begin
    en_low_nxt = enable;
  end

  // Sampled on the falling edge so the enable only moves while the clock is low.
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_low_r <= '0;
    end else begin
      en_low_r <= en_low_nxt;
    end
  end

  // An AND with a low-phase enable cannot cut a high pulse short.
  assign gated_clk = {WIDTH{clk}} & en_low_r;

endmodule
`default_nettype wire

/* File: pbcg_top.sv */
// Peripheral bus clock gating: three mask registers on APB and the gated bus clocks they steer.
// Assumes all three bus domains run from mclk and the APB master is on mclk as well.
// The gated clocks are combinational copies of mclk and cannot leave through a flop.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Domain A bits 6..4 enable interrupt controller, real-time counter, watchdog clocks.
// - Domain A bits 3..0 enable clock unit, system ctrl, power manager, protect zero.
// - Domain B bits 4..0 enable DMA, I/O port, flash, debug, protect one.
// - Domain B mask at 0x1C, five bits reset to one, printed 0x000007F.
// - Domain C bits 19..16 enable touch, DA, comparator and AD converter clocks.
// - Domain C bits 15..11 basic timers, bits 10..8 the control timers.
// - Domain C mask at 0x20 resets 0x00010000; bits 31..20 read zero.
// - Domain C bits 7..2 serial units, bit 1 event system, bit 0 protect two.
module pbcg_top #(
  parameter int WIDTH_A = pbcg_pkg::PBCG_WIDTH_A,
  parameter int WIDTH_B = pbcg_pkg::PBCG_WIDTH_B,
  parameter int WIDTH_C = pbcg_pkg::PBCG_WIDTH_C
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [WIDTH_A-1:0] bus_domain_a_generic_clock_unit_gate,
  output logic [WIDTH_B-1:0] bus_domain_b_generic_clock_unit_gate,
  output logic [WIDTH_C-1:0] bus_domain_c_generic_clock_unit_gate,
  output logic [WIDTH_A-1:0] bus_domain_a_en,
  output logic [WIDTH_B-1:0] bus_domain_b_en,
  output logic [WIDTH_C-1:0] bus_domain_c_en
);

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] pbcg_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Widens a stored mask to a bus word with the upper bits at zero.
  function automatic logic [31:0] pbcg_word(input logic [31:0] mask, input int width);
    logic [31:0] keep;
    keep = (32'h1 << width) - 32'h1;
    return mask & keep;
  endfunction

  // Lowest bit of each field group of the masks.
  localparam int A_UP_LO = pbcg_pkg::PBCG_A_WATCHDOG;
  localparam int C_ANA_LO = pbcg_pkg::PBCG_C_AD_CONVERTER;
  localparam int C_TMR_LO = pbcg_pkg::PBCG_C_BASIC_TIMER_LOW;
  localparam int C_CTMR_LO = pbcg_pkg::PBCG_C_CONTROL_TIMER_LOW;
  localparam int C_SER_LO = pbcg_pkg::PBCG_C_SERIAL_UNIT_LOW;
  localparam int C_EVT_BIT = pbcg_pkg::PBCG_C_EVENT_SYSTEM;
  localparam int C_PROT_BIT = pbcg_pkg::PBCG_C_ACCESS_PROTECT_TWO;

  logic [WIDTH_A-1:0] mask_a_r;
  logic [WIDTH_A-1:0] mask_a_nxt;
  logic [WIDTH_B-1:0] mask_b_r;
  logic [WIDTH_B-1:0] mask_b_nxt;
  logic [WIDTH_C-1:0] mask_c_r;
  logic [WIDTH_C-1:0] mask_c_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_any;
  logic access;
  logic commit;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic [31:0] word_c;
  logic [31:0] merged_a;
  logic [31:0] merged_b;
  logic [31:0] merged_c;
  logic wr_a;
  logic wr_b;
  logic wr_c;

  // Address decode and the access and completion qualifiers.
  assign hit_a = (paddr == pbcg_pkg::PBCG_OFS_MASK_A);
  assign hit_b = (paddr == pbcg_pkg::PBCG_OFS_MASK_B);
  assign hit_c = (paddr == pbcg_pkg::PBCG_OFS_MASK_C);
  assign hit_any = hit_a | hit_b | hit_c;
  assign access = psel & penable;
  assign commit = access & pready_r;

  // Stored masks widened to bus words and merged with the strobed write data.
  assign word_a = pbcg_word(32'(mask_a_r), WIDTH_A);
  assign word_b = pbcg_word(32'(mask_b_r), WIDTH_B);
  assign word_c = pbcg_word(32'(mask_c_r), WIDTH_C);
  assign merged_a = pbcg_merge(word_a, pwdata, pstrb);
  assign merged_b = pbcg_merge(word_b, pwdata, pstrb);
  assign merged_c = pbcg_merge(word_c, pwdata, pstrb);

  // Write strobes per register, true only on the edge that completes the transfer.
  assign wr_a = commit & pwrite & hit_a;
  assign wr_b = commit & pwrite & hit_b;
  assign wr_c = commit & pwrite & hit_c;

  // Bus answer: one wait cycle, then pready and error for a single cycle; prdata holds until the next answer.
  always_comb begin
    pready_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (access && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = ~hit_any;
      if (pwrite || !hit_any) begin
        prdata_nxt = 32'h00000000;
      end else if (hit_a) begin
        prdata_nxt = word_a;
      end else if (hit_b) begin
        prdata_nxt = word_b;
      end else begin
        prdata_nxt = word_c;
      end
    end
  end

  // Bus answer registers; reset leaves the bus idle with no data.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Mask update: a write lands only on the edge that completes its transfer.
  // Each stored bit is one peripheral enable: one passes its clock, zero stops it.
  always_comb begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    mask_c_nxt = mask_c_r;
    if (wr_a) begin
      mask_a_nxt[WIDTH_A-1:A_UP_LO] = merged_a[WIDTH_A-1:A_UP_LO];
      mask_a_nxt[A_UP_LO-1:0] = merged_a[A_UP_LO-1:0];
    end
    if (wr_b) begin
      mask_b_nxt = merged_b[WIDTH_B-1:0];
    end
    if (wr_c) begin
      mask_c_nxt[WIDTH_C-1:C_ANA_LO] = merged_c[WIDTH_C-1:C_ANA_LO];
      mask_c_nxt[C_ANA_LO-1:C_TMR_LO] = merged_c[C_ANA_LO-1:C_TMR_LO];
      mask_c_nxt[C_TMR_LO-1:C_CTMR_LO] = merged_c[C_TMR_LO-1:C_CTMR_LO];
      mask_c_nxt[C_CTMR_LO-1:C_SER_LO] = merged_c[C_CTMR_LO-1:C_SER_LO];
      mask_c_nxt[C_EVT_BIT] = merged_c[C_EVT_BIT];
      mask_c_nxt[C_PROT_BIT] = merged_c[C_PROT_BIT];
    end
  end

  // Mask registers with their documented resets.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_a_r <= pbcg_pkg::PBCG_RST_MASK_A[WIDTH_A-1:0];
      mask_b_r <= pbcg_pkg::PBCG_RST_MASK_B[WIDTH_B-1:0];
      mask_c_r <= pbcg_pkg::PBCG_RST_MASK_C[WIDTH_C-1:0];
    end else begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
      mask_c_r <= mask_c_nxt;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign bus_domain_a_en = mask_a_r;
  assign bus_domain_b_en = mask_b_r;
  assign bus_domain_c_en = mask_c_r;

  // One glitch-free gate bank per bus domain, all fed from the main clock.
  pbcg_clk_gate #(
    .WIDTH(WIDTH_A)
  ) u_gate_a (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(mask_a_r),
    .gated_clk(bus_domain_a_generic_clock_unit_gate)
  );

  pbcg_clk_gate #(
    .WIDTH(WIDTH_B)
  ) u_gate_b (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(mask_b_r),
    .gated_clk(bus_domain_b_generic_clock_unit_gate)
  );

  pbcg_clk_gate #(
    .WIDTH(WIDTH_C)
  ) u_gate_c (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(mask_c_r),
    .gated_clk(bus_domain_c_generic_clock_unit_gate)
  );

endmodule
`default_nettype wire

/* File: pbcg_props.sv */
// Checker for pbcg_top: mask writes and reads, and gated clock shape.
// Assumes it is bound to pbcg_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pbcg_props #(
  parameter int WIDTH_A = 7,
  parameter int WIDTH_B = 5,
  parameter int WIDTH_C = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WIDTH_A-1:0] bus_domain_a_generic_clock_unit_gate,
  input wire logic [WIDTH_B-1:0] bus_domain_b_generic_clock_unit_gate,
  input wire logic [WIDTH_C-1:0] bus_domain_c_generic_clock_unit_gate,
  input wire logic [WIDTH_A-1:0] bus_domain_a_en,
  input wire logic [WIDTH_B-1:0] bus_domain_b_en,
  input wire logic [WIDTH_C-1:0] bus_domain_c_en
);
  logic acc;
  logic wr;
  logic rd;
  // Completed transfer, full-word write and read.
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && pstrb == 4'hF;
  assign rd = acc && !pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Masks take written words, read back, and hold between writes.
  a_write_a: assert property (wr && paddr == 8'h18 |=>
    bus_domain_a_en == $past(pwdata[WIDTH_A-1:0])) else $error("mask A write lost");
  a_write_b: assert property (wr && paddr == 8'h1C |=>
    bus_domain_b_en == $past(pwdata[WIDTH_B-1:0])) else $error("mask B write lost");
  a_write_c: assert property (wr && paddr == 8'h20 |=>
    bus_domain_c_en == $past(pwdata[WIDTH_C-1:0])) else $error("mask C write lost");
  a_read_a: assert property (rd && paddr == 8'h18 |->
    prdata == 32'(bus_domain_a_en)) else $error("mask A read wrong");
  a_read_b: assert property (rd && paddr == 8'h1C |->
    prdata == 32'(bus_domain_b_en)) else $error("mask B read wrong");
  a_read_c: assert property (rd && paddr == 8'h20 |->
    prdata == 32'(bus_domain_c_en)) else $error("mask C read wrong");
  a_mask_hold: assert property (!(acc && pwrite) |=>
    $stable({bus_domain_a_en, bus_domain_b_en, bus_domain_c_en})) else $error("mask moved");
  // Gated clocks are low while the source is low and follow the latched enable.
  a_generic_clock_unit_gate_low: assert property (
    {bus_domain_a_generic_clock_unit_gate, bus_domain_b_generic_clock_unit_gate, bus_domain_c_generic_clock_unit_gate} == '0) else $error("generic_clock_unit_gate high");
  a_generic_clock_unit_gate_follow: assert property (@(negedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> {bus_domain_a_generic_clock_unit_gate, bus_domain_b_generic_clock_unit_gate, bus_domain_c_generic_clock_unit_gate} ==
    $past({bus_domain_a_en, bus_domain_b_en, bus_domain_c_en})) else $error("generic_clock_unit_gate wrong");
  c_write_c: cover property (wr && paddr == 8'h20);
  c_error: cover property (acc && pslverr);
  c_read_a: cover property (rd && paddr == 8'h18);
endmodule
bind pbcg_top pbcg_props #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B), .WIDTH_C(WIDTH_C))
  pbcg_props_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .bus_domain_a_generic_clock_unit_gate, .bus_domain_b_generic_clock_unit_gate, .bus_domain_c_generic_clock_unit_gate,
  .bus_domain_a_en, .bus_domain_b_en, .bus_domain_c_en);
`default_nettype wire

/* File: peripheral_bus_clock_gating_tb.sv */
// Self-checking bench for pbcg_top: APB access to the three masks and gated clocks.
// Assumes pbcg_pkg, pbcg_top and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module peripheral_bus_clock_gating_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] bus_domain_a_generic_clock_unit_gate;
  logic [4:0] bus_domain_b_generic_clock_unit_gate;
  logic [19:0] bus_domain_c_generic_clock_unit_gate;
  logic [6:0] bus_domain_a_en;
  logic [4:0] bus_domain_b_en;
  logic [19:0] bus_domain_c_en;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] ofs [3] = '{8'h18, 8'h1C, 8'h20};
  logic [31:0] lim [3] = '{32'h0000007F, 32'h0000001F, 32'h000FFFFF};
  logic [31:0] rv [3] = '{pbcg_pkg::PBCG_RST_MASK_A, pbcg_pkg::PBCG_RST_MASK_B,
    pbcg_pkg::PBCG_RST_MASK_C};
  // Source clock of 100 ns period.
  always #50 mclk = ~mclk;
  pbcg_top pbcg_top_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .bus_domain_a_generic_clock_unit_gate, .bus_domain_b_generic_clock_unit_gate, .bus_domain_c_generic_clock_unit_gate,
    .bus_domain_a_en, .bus_domain_b_en, .bus_domain_c_en);
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  // Reset values, walking ones, strobes, unmapped access, gated clocks, second reset.
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int d = 0; d < 3; d++) begin
      apb(1'b0, ofs[d], 32'h0, 4'hF);
      chk(rd, rv[d] & lim[d]);
      chk({31'h0, er}, 32'h0);
      for (int i = 0; i < 32; i++) begin
        apb(1'b1, ofs[d], 32'h1 << i, 4'hF);
        apb(1'b0, ofs[d], 32'h0, 4'hF);
        chk(rd, (32'h1 << i) & lim[d]);
      end
      $display("mask %0d test done", d);
    end
    apb(1'b1, 8'h20, 32'hFFFFFFFF, 4'h2);
    apb(1'b1, 8'h24, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h24, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    chk(rd, 32'h0000FF00);
    $display("strobe and unmapped test done");
    apb(1'b1, 8'h18, 32'h55, 4'hF);
    repeat (2) @(posedge mclk);
    #25;
    chk(32'(bus_domain_a_generic_clock_unit_gate), 32'h55);
    chk(32'(bus_domain_c_generic_clock_unit_gate), 32'h0000FF00);
    chk(32'(bus_domain_a_en), 32'h55);
    chk(32'(bus_domain_b_generic_clock_unit_gate), 32'h0);
    #50;
    chk(32'({bus_domain_a_generic_clock_unit_gate, bus_domain_c_generic_clock_unit_gate}), 32'h0);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    chk(rd, 32'h00010000);
    chk(32'(bus_domain_b_en), 32'h0000001F);
    #25;
    chk(32'(bus_domain_a_generic_clock_unit_gate), 32'h0000007F);
    chk(32'(bus_domain_b_generic_clock_unit_gate), 32'h0000001F);
    chk(32'(bus_domain_c_generic_clock_unit_gate), 32'h00010000);
    $display("clock and reset test done");
    summarize();
  end
endmodule
`default_nettype wire
